// [inc/dmm_pkg.sv]
package dmm_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STACK_POINTER = 8'h81;
  localparam logic [7:0] ADDR_ONCHIP_EXTERNAL_RAM_PAGE_CONTROL = 8'hAA;
  localparam logic [7:0] ADDR_DERIVATIVE_IDENTITY = 8'hAB;
  localparam logic [7:0] ADDR_SILICON_REVISION = 8'hAC;
  localparam logic [7:0] ADDR_SERIAL_BYTE_LOW = 8'hAB;
  localparam logic [7:0] ADDR_SERIAL_BYTE_ONE = 8'hAC;
  localparam logic [7:0] ADDR_SERIAL_BYTE_TWO = 8'hAD;
  localparam logic [7:0] ADDR_SERIAL_BYTE_HIGH = 8'hAE;

  // ----------------------------------------------------------------
  // pages, fields, resets
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic [7:0] PAGE_F = 8'h0F;
  localparam int PSW_BANK_LOW_POS = 3;
  localparam int PSW_BANK_HIGH_POS = 4;
  localparam logic [7:0] STACK_POINTER_RESET = 8'h07;
  localparam logic [7:0] LOWER_RAM_TOP = 8'h7F;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam int PAGE_FIELD_W = 2;
  localparam logic [1:0] PAGE_FIELD_RESET = 2'h0;
  localparam logic [5:0] PAGE_CTRL_UNUSED = 6'h00;
  localparam int ONCHIP_EXTERNAL_RAM_BYTES = 768;
  localparam int XADDR_W = 10;
  localparam logic [7:0] ONCHIP_EXTERNAL_RAM_EMPTY_READ = 8'h00;

endpackage : dmm_pkg

// [rtl/dmm_data_memory.sv]
`timescale 1ns/100ps
module dmm_data_memory #(
  parameter logic [7:0] DERIV_ID = 8'h5A, // value is arbitrary
  parameter logic [7:0] REV_ID = 8'h01, // value is arbitrary
  parameter logic [31:0] SERIAL_NUMBER = 32'h1234_5678, // value is arbitrary
  parameter int ONCHIP_EXTERNAL_RAM_BYTES = dmm_pkg::ONCHIP_EXTERNAL_RAM_BYTES
) (
  input wire logic clk,
  input wire logic rstn,
  // core status
  input wire logic [7:0] programStatusWord,
  input wire logic [7:0] registerPageSelect,
  input wire logic ptrSel,
  // internal data access
  input wire logic iReq,
  input wire logic iWe,
  input wire logic iIndirect,
  input wire logic iRegMode,
  input wire logic iBitMode,
  input wire logic [7:0] iAddr,
  input wire logic [7:0] iWdata,
  input wire logic iWbit,
  output logic [7:0] iRdata,
  output logic iRbit,
  output logic iRvalid,
  output logic sfrHit,
  // stack
  input wire logic pushReq,
  input wire logic [7:0] pushData,
  input wire logic popReq,
  output logic [7:0] stackPointer,
  // external data access
  input wire logic xReq,
  input wire logic xWe,
  input wire logic xWide,
  input wire logic [15:0] dataPointer16,
  input wire logic [7:0] xWdata,
  input wire logic flashWriteMode,
  output logic [7:0] xRdata,
  output logic xRvalid,
  output logic [1:0] xramPageField
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // bank n occupies 8n..8n+7
  function automatic logic [7:0] bankAddr(input logic [1:0] bank,
                                          input logic [2:0] idx);
    bankAddr = {3'h0, bank, idx};
  endfunction : bankAddr

  function automatic logic [7:0] bitMerge(input logic [7:0] cur,
                                          input logic [2:0] pos,
                                          input logic val);
    logic [7:0] res;
    res = cur;
    res[pos] = val;
    bitMerge = res;
  endfunction : bitMerge

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rstMeta_ff;
  logic rstSync_ff;
  wire rstnInt = rstSync_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // lower and upper halves in one array; upper only via pointer or stack
  logic [7:0] iram [0:255];
  logic [7:0] onchip_external_ram [0:ONCHIP_EXTERNAL_RAM_BYTES-1];

  // ----------------------------------------------------------------
  // bank and pointer
  // ----------------------------------------------------------------
  wire [1:0] activeBank = {programStatusWord[dmm_pkg::PSW_BANK_HIGH_POS],
                           programStatusWord[dmm_pkg::PSW_BANK_LOW_POS]};
  wire [7:0] ptrAddr = bankAddr(activeBank, {2'h0, ptrSel});
  wire [7:0] ptrVal = iram[ptrAddr];

  // ----------------------------------------------------------------
  // internal access decode
  // ----------------------------------------------------------------
  wire [7:0] regAddr = bankAddr(activeBank, iAddr[2:0]);
  wire directUpper = iAddr > dmm_pkg::LOWER_RAM_TOP;

  // ----------------------------------------------------------------
  // bit addressing
  // ----------------------------------------------------------------
  // bit address: byte index in 6:3, bit position in 2:0
  wire [2:0] bitPos = iAddr[2:0];
  wire [3:0] bitByteIdx = iAddr[6:3];
  wire bitInSfr = iAddr[7];
  wire [7:0] bitByteAddr = dmm_pkg::BIT_AREA_BASE + {4'h0, bitByteIdx};
  // bit addresses 0x80 and up belong to register space
  wire toSfr = iReq & ~iIndirect & ~iRegMode &
               (iBitMode ? bitInSfr : directUpper);
  // indirect reaches all 256; direct only the lower half
  wire [7:0] byteAddr = iRegMode ? regAddr :
                        iIndirect ? ptrVal : iAddr;
  wire [7:0] ramAddr = (iBitMode & ~iIndirect & ~iRegMode) ?
                       bitByteAddr : byteAddr;
  wire bitAccess = iBitMode & ~iIndirect & ~iRegMode;
  wire [7:0] ramByte = iram[ramAddr];
  wire ramHit = iReq & ~toSfr;
  wire ramWr = ramHit & iWe;
  wire [7:0] ramWdata = bitAccess ?
                        bitMerge(ramByte, bitPos, iWbit) : iWdata;

  // ----------------------------------------------------------------
  // stack
  // ----------------------------------------------------------------
  logic [7:0] stackPointer_ff;
  logic [7:0] nxt_stackPointer;
  wire [7:0] pushAddr = stackPointer_ff + 8'h01;
  wire [7:0] popAddr = stackPointer_ff - 8'h01;
  wire [7:0] popByte = iram[stackPointer_ff];

  // ----------------------------------------------------------------
  // register page decode
  // ----------------------------------------------------------------
  wire onPage0 = registerPageSelect == dmm_pkg::PAGE_ZERO;
  wire onPageF = registerPageSelect == dmm_pkg::PAGE_F;
  wire sfrWr = toSfr & iWe & ~bitAccess;

  // ----------------------------------------------------------------
  // owned register hits
  // ----------------------------------------------------------------
  wire hitSp = iAddr == dmm_pkg::ADDR_STACK_POINTER;
  wire hitPageCtrl = iAddr == dmm_pkg::ADDR_ONCHIP_EXTERNAL_RAM_PAGE_CONTROL;
  wire hitDeriv = onPage0 & (iAddr == dmm_pkg::ADDR_DERIVATIVE_IDENTITY);
  wire hitRev = onPage0 & (iAddr == dmm_pkg::ADDR_SILICON_REVISION);
  wire hitSn0 = onPageF & (iAddr == dmm_pkg::ADDR_SERIAL_BYTE_LOW);
  wire hitSn1 = onPageF & (iAddr == dmm_pkg::ADDR_SERIAL_BYTE_ONE);
  wire hitSn2 = onPageF & (iAddr == dmm_pkg::ADDR_SERIAL_BYTE_TWO);
  wire hitSn3 = onPageF & (iAddr == dmm_pkg::ADDR_SERIAL_BYTE_HIGH);
  wire ownSfr = hitSp | hitPageCtrl | hitDeriv | hitRev |
                hitSn0 | hitSn1 | hitSn2 | hitSn3;
  wire sfrOwned = toSfr & ~bitAccess & ownSfr;

  // ----------------------------------------------------------------
  // serial number registers
  // ----------------------------------------------------------------
  // serial bytes double as scratch registers when unused
  logic [7:0] serialLow_ff;
  logic [7:0] serialOne_ff;
  logic [7:0] serialTwo_ff;
  logic [7:0] serialHigh_ff;
  wire wrSerialLow = sfrWr & hitSn0;
  wire wrSerialOne = sfrWr & hitSn1;
  wire wrSerialTwo = sfrWr & hitSn2;
  wire wrSerialHigh = sfrWr & hitSn3;
  wire [7:0] nxt_serialLow = wrSerialLow ? iWdata : serialLow_ff;
  wire [7:0] nxt_serialOne = wrSerialOne ? iWdata : serialOne_ff;
  wire [7:0] nxt_serialTwo = wrSerialTwo ? iWdata : serialTwo_ff;
  wire [7:0] nxt_serialHigh = wrSerialHigh ? iWdata : serialHigh_ff;

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      serialLow_ff <= SERIAL_NUMBER[7:0];
    end else begin
      serialLow_ff <= nxt_serialLow;
    end
  end

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      serialOne_ff <= SERIAL_NUMBER[15:8];
    end else begin
      serialOne_ff <= nxt_serialOne;
    end
  end

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      serialTwo_ff <= SERIAL_NUMBER[23:16];
    end else begin
      serialTwo_ff <= nxt_serialTwo;
    end
  end

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      serialHigh_ff <= SERIAL_NUMBER[31:24];
    end else begin
      serialHigh_ff <= nxt_serialHigh;
    end
  end

  // ----------------------------------------------------------------
  // page control register
  // ----------------------------------------------------------------
  logic [1:0] pageField_ff;
  wire wrPageCtrl = sfrWr & hitPageCtrl;
  wire [1:0] nxt_pageField = wrPageCtrl ? iWdata[dmm_pkg::PAGE_FIELD_W-1:0] : pageField_ff;
  // upper six bits have no storage and always read zero
  wire [7:0] pageCtrlRead = {dmm_pkg::PAGE_CTRL_UNUSED, pageField_ff};

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      pageField_ff <= dmm_pkg::PAGE_FIELD_RESET;
    end else begin
      pageField_ff <= nxt_pageField;
    end
  end

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  // identity and revision have no storage, so writes fall away
  wire [7:0] sfrRead = hitSp ? stackPointer_ff :
                       hitPageCtrl ? pageCtrlRead :
                       hitDeriv ? DERIV_ID :
                       hitRev ? REV_ID :
                       hitSn0 ? serialLow_ff :
                       hitSn1 ? serialOne_ff :
                       hitSn2 ? serialTwo_ff :
                       hitSn3 ? serialHigh_ff :
                       8'h00;

  // ----------------------------------------------------------------
  // stack pointer
  // ----------------------------------------------------------------
  wire wrStackPointer = sfrWr & hitSp;
  // push wins over pop and over a direct write in the same cycle
  assign nxt_stackPointer = pushReq ? pushAddr :
                            popReq ? popAddr :
                            wrStackPointer ? iWdata :
                            stackPointer_ff;

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      stackPointer_ff <= dmm_pkg::STACK_POINTER_RESET;
    end else begin
      stackPointer_ff <= nxt_stackPointer;
    end
  end

  // ----------------------------------------------------------------
  // internal RAM write port
  // ----------------------------------------------------------------
  // one port: a push takes precedence over a data write
  wire iramWrEn = pushReq | ramWr;
  wire [7:0] iramWrAddr = pushReq ? pushAddr : ramAddr;
  wire [7:0] iramWrData = pushReq ? pushData : ramWdata;

  always_ff @(posedge clk) begin
    if (iramWrEn) begin
      iram[iramWrAddr] <= iramWrData;
    end
  end

  // ----------------------------------------------------------------
  // internal read results
  // ----------------------------------------------------------------
  logic [7:0] iRdata_ff;
  logic iRbit_ff;
  logic iRvalid_ff;
  logic sfrHit_ff;
  wire iRdValidNow = (iReq & ~iWe) | popReq;
  // a pop reads the stack, never a register
  wire nxt_sfrHit = sfrOwned & ~popReq;

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      iRvalid_ff <= 1'b0;
    end else begin
      iRvalid_ff <= iRdValidNow;
    end
  end

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      sfrHit_ff <= 1'b0;
    end else begin
      sfrHit_ff <= nxt_sfrHit;
    end
  end

  // ----------------------------------------------------------------
  // internal read data
  // ----------------------------------------------------------------
  // data holds between reads so the core may take it late
  wire [7:0] nxt_iRdata = popReq ? popByte :
                          toSfr ? sfrRead : ramByte;
  wire nxt_iRbit = ramHit & bitAccess & ramByte[bitPos];

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      iRdata_ff <= 8'h00;
    end else if (iRdValidNow) begin
      iRdata_ff <= nxt_iRdata;
    end
  end

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      iRbit_ff <= 1'b0;
    end else if (iRdValidNow) begin
      iRbit_ff <= nxt_iRbit;
    end
  end

  // ----------------------------------------------------------------
  // output ports
  // ----------------------------------------------------------------
  assign iRdata = iRdata_ff;
  assign iRbit = iRbit_ff;
  assign iRvalid = iRvalid_ff;
  assign sfrHit = sfrHit_ff;
  assign stackPointer = stackPointer_ff;
  assign xramPageField = pageField_ff;

  // ----------------------------------------------------------------
  // external data decode
  // ----------------------------------------------------------------
  // top six address bits dropped: 1 kB image repeats over 64 kB
  wire [dmm_pkg::XADDR_W-1:0] wideAddr = dataPointer16[dmm_pkg::XADDR_W-1:0];
  wire [dmm_pkg::XADDR_W-1:0] narrowAddr = {pageField_ff, ptrVal};
  wire [dmm_pkg::XADDR_W-1:0] xAddr = xWide ? wideAddr : narrowAddr;
  wire xInRam = {22'h0, xAddr} < ONCHIP_EXTERNAL_RAM_BYTES;
  wire [7:0] xRamByte = xInRam ? onchip_external_ram[xAddr] : dmm_pkg::ONCHIP_EXTERNAL_RAM_EMPTY_READ;

  // ----------------------------------------------------------------
  // external RAM write port
  // ----------------------------------------------------------------
  wire xWrNow = xReq & xWe;
  // flash-write mode steals writes only; reads stay on RAM
  wire xWrAllowed = ~flashWriteMode & xInRam;
  wire xWr = xWrNow & xWrAllowed;

  always_ff @(posedge clk) begin
    if (xWr) begin
      onchip_external_ram[xAddr] <= xWdata;
    end
  end

  // ----------------------------------------------------------------
  // external read results
  // ----------------------------------------------------------------
  logic [7:0] xRdata_ff;
  logic xRvalid_ff;
  wire xRdNow = xReq & ~xWe;

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      xRvalid_ff <= 1'b0;
    end else begin
      xRvalid_ff <= xRdNow;
    end
  end

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      xRdata_ff <= 8'h00;
    end else if (xRdNow) begin
      xRdata_ff <= xRamByte;
    end
  end

  assign xRdata = xRdata_ff;
  assign xRvalid = xRvalid_ff;

endmodule : dmm_data_memory

// [dv/dmm_data_memory_asserts.sv]
`timescale 1ns/100ps
module dmm_data_memory_asserts #(
  parameter logic [7:0] DERIV_ID = 8'h3B // value is arbitrary
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] registerPageSelect,
  input wire logic iReq,
  input wire logic iWe,
  input wire logic iIndirect,
  input wire logic iRegMode,
  input wire logic iBitMode,
  input wire logic [7:0] iAddr,
  input wire logic [7:0] iRdata,
  input wire logic iRvalid,
  input wire logic sfrHit,
  input wire logic pushReq,
  input wire logic popReq,
  input wire logic [7:0] stackPointer,
  input wire logic xReq,
  input wire logic xWe,
  input wire logic xWide,
  input wire logic [15:0] dataPointer16,
  input wire logic [7:0] xRdata,
  input wire logic xRvalid,
  input wire logic [1:0] xramPageField
);
  // ----------------------------------------
  // port timing relations
  // ----------------------------------------
  wire logic dirRd = iReq && !iWe && !iIndirect && !iRegMode && !iBitMode;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_read_answer: assert property (iReq && !iWe |=> iRvalid)
    else $error("read got no answer");
  chk_write_quiet: assert property (iReq && iWe && !popReq |=> !iRvalid)
    else $error("write produced an answer");
  chk_push_step: assert property (pushReq |=> stackPointer == $past(stackPointer) + 8'h01)
    else $error("push did not advance pointer");
  chk_pop_step: assert property (popReq && !pushReq |=> stackPointer == $past(stackPointer) - 8'h01)
    else $error("pop did not retreat pointer");
  chk_sp_read: assert property (dirRd && iAddr == 8'h81 && !pushReq && !popReq
    |=> sfrHit && iRdata == $past(stackPointer))
    else $error("pointer register read wrong");
  chk_ptr_nosfr: assert property (iReq && (iIndirect || iRegMode) |=> !sfrHit)
    else $error("indirect access hit registers");
  chk_bit_nosfr: assert property (iReq && iBitMode && !iIndirect && !iRegMode && iAddr[7]
    |=> !sfrHit)
    else $error("bit access hit registers");
  chk_page_read: assert property (dirRd && iAddr == 8'hAA |=> iRdata == {6'h00, xramPageField})
    else $error("page control read wrong");
  chk_deriv_read: assert property (dirRd && iAddr == 8'hAB && registerPageSelect == 8'h00
    |=> sfrHit && iRdata == DERIV_ID)
    else $error("derivative read wrong");
  chk_xread_answer: assert property (xReq && !xWe |=> xRvalid)
    else $error("external read got no answer");
  chk_xempty_zero: assert property (xReq && !xWe && xWide && dataPointer16[9:8] == 2'h3
    |=> xRdata == 8'h00)
    else $error("empty external range not zero");
  cov_push: cover property (pushReq);
  cov_xempty: cover property (xReq && !xWe && xWide && dataPointer16[9:8] == 2'h3);
  cov_deriv: cover property (dirRd && iAddr == 8'hAB && registerPageSelect == 8'h00);
endmodule : dmm_data_memory_asserts
bind dmm_data_memory dmm_data_memory_asserts #(.DERIV_ID(DERIV_ID)) u_chk (.*);

// [dv/dmm_core_model.sv]
`timescale 1ns/100ps
module dmm_core_model (
  input wire logic clk,
  output logic iReq,
  output logic iWe,
  output logic iIndirect,
  output logic iRegMode,
  output logic iBitMode,
  output logic [7:0] iAddr,
  output logic [7:0] iWdata,
  output logic iWbit,
  output logic pushReq,
  output logic [7:0] pushData,
  output logic popReq,
  output logic xReq,
  output logic xWe,
  output logic xWide,
  output logic [15:0] dataPointer16,
  output logic [7:0] xWdata
);
  initial begin
    {iReq, iWe, iIndirect, iRegMode, iBitMode, iAddr, iWdata, iWbit} = '0;
    {pushReq, pushData, popReq, xReq, xWe, xWide, dataPointer16, xWdata} = '0;
  end
  // released lines show the inverse so a stale value never looks valid
  task automatic acc(input logic [3:0] m, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    {iWe, iIndirect, iRegMode, iBitMode} = m;
    {iReq, iAddr, iWdata, iWbit} = {1'b1, a, d, d[0]};
    @(posedge clk);
    #2;
    {iReq, iAddr, iWdata} = {1'b0, ~a, ~d};
  endtask : acc
  task automatic xacc(input logic we, input logic wide, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    {xReq, xWe, xWide, dataPointer16, xWdata} = {1'b1, we, wide, a, d};
    @(posedge clk);
    #2;
    {xReq, dataPointer16, xWdata} = {1'b0, ~a, ~d};
  endtask : xacc
  task automatic stk(input logic push, input logic [7:0] d);
    @(posedge clk);
    #2;
    {pushReq, popReq, pushData} = {push, !push, d};
    @(posedge clk);
    #2;
    {pushReq, popReq, pushData} = {2'b00, ~d};
  endtask : stk
endmodule : dmm_core_model

// [dv/dmm_data_memory_tb.sv]
`timescale 1ns/100ps
module dmm_data_memory_tb;
  localparam logic [7:0] DID = 8'h3B; // value is arbitrary
  localparam logic [7:0] RID = 8'h02; // value is arbitrary
  localparam logic [31:0] SN = 32'h9A7E_4C21; // value is arbitrary
  logic clk = 1'b0, rstn = 1'b0, ptrSel = 1'b0, flashWriteMode = 1'b0;
  logic [7:0] programStatusWord = 8'h00, registerPageSelect = 8'h00;
  wire logic iReq, iWe, iIndirect, iRegMode, iBitMode, iWbit, pushReq, popReq, xReq, xWe, xWide;
  wire logic [7:0] iAddr, iWdata, pushData, xWdata;
  wire logic [15:0] dataPointer16;
  logic [7:0] iRdata, stackPointer, xRdata, a;
  logic [1:0] xramPageField;
  logic iRbit, iRvalid, sfrHit, xRvalid;
  logic [9:0] iq[$], e;
  logic [7:0] xq[$];
  logic [31:0] seed = 32'hF0B2, v;
  logic [15:0] xa;
  int fail_count = 0, checks = 0, cycles = 0;
  dmm_data_memory #(.DERIV_ID(DID), .REV_ID(RID), .SERIAL_NUMBER(SN)) u_dut (.*);
  dmm_core_model u_core (.*);
  always #10 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  // modes {write, indirect, register, bit}; bit results flagged in bit 9
  task automatic rd(input logic [3:0] m, input logic [7:0] ad, input logic [9:0] x);
    iq.push_back(x);
    u_core.acc(m, ad, 8'h00);
  endtask : rd
  task automatic xrd(input logic [15:0] ad, input logic [7:0] x);
    xq.push_back(x);
    u_core.xacc(1'b0, 1'b1, ad, 8'h00);
  endtask : xrd
  // ----------------------------------------
  // result watcher, also the hang limit
  // ----------------------------------------
  always @(negedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      fail_count++;
      print_verdict();
    end
    if (iRvalid === 1'b1) begin
      e = (iq.size() > 0) ? iq.pop_front() : 10'h3FF;
      if (e[9]) check("rbit", {7'h00, iRbit}, {7'h00, e[8]});
      else check("rdata", iRdata, e[7:0]);
    end
    if (xRvalid === 1'b1) check("xrdata", xRdata, (xq.size() > 0) ? xq.pop_front() : 8'hEE);
  end
  initial begin
    repeat (16) @(posedge clk);
    #2 rstn = 1'b1;
    repeat (3) @(posedge clk);
    check("sp", stackPointer, 8'h07);
    check("pgfield", {6'h00, xramPageField}, 8'h00);
    rd(4'h0, 8'hAA, 10'h000);
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      a = (i == 0) ? 8'h7F : {1'b0, v[6:0]};
      u_core.acc(4'h8, a, v[15:8]);
      rd(4'h0, a, {2'b00, v[15:8]});
    end
    for (int b = 0; b < 4; b++) begin
      programStatusWord = {3'h0, 2'(b), 3'h0};
      ptrSel = b[0];
      u_core.acc(4'h8, 8'(8 * b + b % 2), 8'(8'hA0 + b));
      u_core.acc(4'hC, 8'h00, 8'(8'h50 + b));
      rd(4'h2, {7'h00, ptrSel}, 10'(8'hA0 + b));
      rd(4'h4, 8'h00, 10'(8'h50 + b));
    end
    u_core.acc(4'h8, 8'hA3, 8'hEE);
    rd(4'h4, 8'h00, 10'h053);
    u_core.acc(4'h8, 8'h22, 8'h00);
    u_core.acc(4'h9, 8'h13, 8'h01);
    rd(4'h0, 8'h22, 10'h008);
    u_core.acc(4'h8, 8'h2F, 8'h80);
    rd(4'h1, 8'h7F, 10'h300);
    rd(4'h1, 8'h80, 10'h200);
    u_core.stk(1'b1, 8'h3C);
    check("sp", stackPointer, 8'h08);
    rd(4'h0, 8'h08, 10'h03C);
    u_core.acc(4'h8, 8'h81, 8'hFF);
    u_core.stk(1'b1, 8'h6D);
    check("sp", stackPointer, 8'h00);
    iq.push_back(10'h06D);
    u_core.stk(1'b0, 8'h00);
    rd(4'h0, 8'h81, 10'h0FF);
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      xa = {v[31:26], 2'(i % 3), v[7:0]};
      u_core.xacc(1'b1, 1'b1, xa, v[23:16]);
      xrd({~v[31:26], xa[9:0]}, v[23:16]);
    end
    u_core.xacc(1'b1, 1'b1, 16'h0355, 8'h77);
    xrd(16'h0355, 8'h00);
    u_core.acc(4'h8, 8'hAA, 8'hFD);
    rd(4'h0, 8'hAA, 10'h001);
    check("pgfield", {6'h00, xramPageField}, 8'h01);
    u_core.acc(4'h8, 8'h19, 8'h34);
    u_core.xacc(1'b1, 1'b0, 16'hFFFF, 8'h5E);
    xrd(16'h0134, 8'h5E);
    flashWriteMode = 1'b1;
    u_core.xacc(1'b1, 1'b1, 16'h0134, 8'h11);
    flashWriteMode = 1'b0;
    xrd(16'h0134, 8'h5E);
    u_core.acc(4'h8, 8'hAB, 8'hFF);
    rd(4'h0, 8'hAB, {2'b00, DID});
    rd(4'h0, 8'hAC, {2'b00, RID});
    registerPageSelect = 8'h0F;
    for (int j = 0; j < 4; j++) rd(4'h0, 8'(8'hAB + j), {2'b00, SN[8 * j +: 8]});
    u_core.acc(4'h8, 8'hAD, 8'hC3);
    rd(4'h0, 8'hAD, 10'h0C3);
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule : dmm_data_memory_tb
